// File: design/nrd_cfg.svh
`ifndef NRD_CFG_SVH
`define NRD_CFG_SVH

// register indices; byte address is four times the index
`define NRD_IDX_IO_CFG1     6'h00
`define NRD_IDX_IO_CFG2     6'h01
`define NRD_IDX_OP_CTRL     6'h02
`define NRD_IDX_MODE_DEF    6'h03
`define NRD_IDX_BITRATE_DEF 6'h04
`define NRD_IDX_TYPE_A      6'h05
`define NRD_IDX_AUX_DEF     6'h09
`define NRD_IDX_RX_CONF3    6'h0C
`define NRD_IDX_NRT_CTRL    6'h10
`define NRD_IDX_IRQ_STAT    6'h1A
`define NRD_IDX_COLLISION   6'h1B
`define NRD_IDX_BR_DISPLAY  6'h1C
`define NRD_IDX_COMMAND     6'h3F

// reset values
`define NRD_RST_REG8        8'h00

// operation control fields
`define NRD_OP_EN           7
`define NRD_OP_RX_EN        6
`define NRD_OP_SINGLE_RX    5
`define NRD_OP_TX_EN        3

// mode definition fields
`define NRD_MODE_TARGET     7
`define NRD_MODE_OM_HI      6
`define NRD_MODE_OM_LO      3
`define NRD_MODE_AUTO_RESP  0
`define NRD_OM_NFC_INIT     4'h1
`define NRD_OM_NFC_TARGET   4'h1
`define NRD_OM_BR_DETECT    4'h2

// auxiliary definition fields
`define NRD_AUX_TX_MOD_TYPE 5
`define NRD_AUX_FIELD_DET   4
`define NRD_AUX_SLOT_HI     1
`define NRD_AUX_SLOT_LO     0

// other fields
`define NRD_TYPE_A_START_LEN 5
`define NRD_RXC3_LIMIT       1
`define NRD_RXC3_GAIN_RED    0
`define NRD_NRT_KEEP         0
`define NRD_IRQ_CAT          1
`define NRD_IRQ_CAC          0

// command codes
`define NRD_CMD_SET_DEFAULT  8'hC1
`define NRD_CMD_CLEAR        8'hC2
`define NRD_CMD_TX_CRC       8'hC4
`define NRD_CMD_TX_NOCRC     8'hC5
`define NRD_CMD_TX_REQA      8'hC6
`define NRD_CMD_TX_WUPA      8'hC7
`define NRD_CMD_INIT_FIELD   8'hC8
`define NRD_CMD_RESP_FIELD   8'hC9
`define NRD_CMD_RESP_FIELD0  8'hCA
`define NRD_CMD_GO_NORMAL    8'hCB
`define NRD_CMD_ANALOG_PRE   8'hCC

// timing, carrier in kHz, clock in kHz
`define NRD_CLK_KHZ          100000
`define NRD_FC_KHZ           13560
`define NRD_IDT_FC           4096
`define NRD_RWF_FC           512
`define NRD_ADT_FC           768
`define NRD_ARFG_FC          1024
`define NRD_IRFG_MS          5
`define NRD_FC_CYC(p) (((p) * `NRD_CLK_KHZ + `NRD_FC_KHZ - 1) / `NRD_FC_KHZ)
`define NRD_MS_CYC(m) ((m) * `NRD_CLK_KHZ + 1)

`endif

// File: design/nrd_pkg.sv
package nrd_pkg;
	typedef enum logic [1:0] {
		NRD_CA_IDLE  = 2'b00,
		NRD_CA_DELAY = 2'b01,
		NRD_CA_SLOTS = 2'b11,
		NRD_CA_GUARD = 2'b10
	} nrd_ca_state_t;

	typedef enum logic [1:0] {
		NRD_TX_CRC   = 2'b00,
		NRD_TX_NOCRC = 2'b01,
		NRD_TX_REQA  = 2'b10,
		NRD_TX_WUPA  = 2'b11
	} nrd_tx_kind_t;
endpackage

// File: design/nrd_cmd_exec.sv
`timescale 1ns/1ps
`include "nrd_cfg.svh"

// Summary of operation
// [RULE1] restore defaults resets all registers but both io configs and op control
// [RULE2] restore defaults also discards calibration and adjustment results
// [RULE3] restore defaults always accepted; fifo kept when master enable is low
// [RULE4] restore defaults is never chained and raises no completion flag
// [RULE5] clear aborts tx and rx, empties fifo, stops timers but wake-up
// [RULE6] with no-response keep bit set, clear leaves that timer running
// [RULE7] with auto response avoidance set, clear keeps the avoidance sequence
// [RULE8] clear also resets collision and interrupt registers
// [RULE9] clear needs enable and stable oscillator; chainable, no completion flag
// [RULE10] host issues clear, byte count, then payload before data transmit
// [RULE11] every transmit command needs the transmitter enable bit
// [RULE12] host zeroes last-byte bit count before REQA or WUPA
// [RULE13] field-on senses rf; if quiet enables tx, flags done after guard
// [RULE14] external field flags collision, tx stays off; host repeats command
// [RULE15] initial field-on waits 4096 carrier periods, n slots, guard over 5 ms
// [RULE16] response field-on uses slot bits for n; its variant forces n to 0
// [RULE17] response avoidance delay 768 and guard 1024 carrier periods
// [RULE18] field-on needs enable plus stable oscillator frequency and amplitude
// [RULE19] go-to-normal leaves detection mode, copies bit rate, sets mod type
// [RULE20] analog preset loads rx and tx bits from mode and bit rate
// [RULE21] active mode preset sets single rx channel and clears tx enable
// [RULE22] target or initiator preset clears tx enable
// [RULE23] active mode preset sets start and length byte insertion
// [RULE24] a command whose conditions fail is ignored entirely
module nrd_cmd_exec #(
	parameter logic [19:0] P_IDT_CYC  = 20'(`NRD_FC_CYC(`NRD_IDT_FC)),
	parameter logic [19:0] P_ADT_CYC  = 20'(`NRD_FC_CYC(`NRD_ADT_FC)),
	parameter logic [19:0] P_ARFG_CYC = 20'(`NRD_FC_CYC(`NRD_ARFG_FC)),
	parameter logic [19:0] P_IRFG_CYC = 20'(`NRD_MS_CYC(`NRD_IRFG_MS))
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog status pins
	input  wire logic        osc_freq_ok,
	input  wire logic        osc_ampl_ok,
	input  wire logic        ext_field,
	// from framing logic
	input  wire logic        coll_evt,
	input  wire logic [7:0]  coll_pos,
	input  wire logic [7:0]  br_detected,
	// configuration outputs
	output logic      [7:0]  op_ctrl,
	output logic      [7:0]  mode_def,
	output logic      [7:0]  bitrate_def,
	output logic      [7:0]  type_a_cfg,
	output logic      [7:0]  aux_def,
	output logic      [7:0]  rx_conf3,
	// action pulses
	output logic             trx_abort,
	output logic             fifo_clear,
	output logic             timers_stop,
	output logic             nrt_stop,
	output logic             calib_discard,
	output logic             tx_start,
	output logic      [1:0]  tx_kind,
	// event flags
	output logic      [1:0]  irq_flags
);
	localparam logic [19:0] RWF_CYC = 20'(`NRD_FC_CYC(`NRD_RWF_FC));

	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       field_prev_q;
	logic [7:0] io_cfg1_q;
	logic [7:0] io_cfg2_q;
	logic [7:0] op_ctrl_q;
	logic [7:0] mode_q;
	logic [7:0] bitrate_q;
	logic [7:0] type_a_q;
	logic [7:0] aux_q;
	logic [7:0] rxc3_q;
	logic [7:0] nrt_ctrl_q;
	logic [1:0] irq_q;
	logic [7:0] coll_q;
	logic [31:0] prdata_q;
	logic       trx_abort_q;
	logic       fifo_clear_q;
	logic       timers_stop_q;
	logic       nrt_stop_q;
	logic       calib_discard_q;
	logic       tx_start_q;
	logic [1:0] tx_kind_q;
	nrd_pkg::nrd_ca_state_t ca_q;
	logic [19:0] cnt_q;
	logic [1:0]  slots_q;
	logic        ca_init_q;
	logic [7:0]  lfsr_q;

	logic        freq_ok;
	logic        ampl_ok;
	logic        field;
	logic        wr_acc;
	logic [5:0]  idx;
	logic        mapped;
	logic        cmd_wr;
	logic [7:0]  cmd;
	logic        en;
	logic        do_setdef;
	logic        do_clear;
	logic        do_tx;
	logic        do_fon_init;
	logic        do_fon_resp;
	logic        do_fon_resp0;
	logic        do_go_normal;
	logic        do_preset;
	logic        auto_start;
	logic        ca_start;
	logic        ca_abort;
	logic        ca_tick0;
	logic        ca_tx_on;
	logic        ca_cat;
	logic        ca_cac;
	logic [1:0]  slot_max;
	logic [1:0]  slot_rand;
	logic [3:0]  om;
	logic        active_comm;
	logic        tx_am;

	// pin inputs, two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {ext_field, osc_ampl_ok, osc_freq_ok};
			sync2_q <= sync1_q;
		end
	end

	assign freq_ok = sync2_q[0];
	assign ampl_ok = sync2_q[1];
	assign field   = sync2_q[2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			field_prev_q <= 1'b0;
		else
			field_prev_q <= field;
	end

	// apb decode; zero wait state
	assign idx    = paddr[7:2];
	assign wr_acc = psel && penable && pwrite;
	assign cmd_wr = wr_acc && (idx == `NRD_IDX_COMMAND);
	assign cmd    = pwdata[7:0];
	assign en     = op_ctrl_q[`NRD_OP_EN];

	always_comb begin
		unique case (idx)
		`NRD_IDX_IO_CFG1, `NRD_IDX_IO_CFG2, `NRD_IDX_OP_CTRL,
		`NRD_IDX_MODE_DEF, `NRD_IDX_BITRATE_DEF, `NRD_IDX_TYPE_A,
		`NRD_IDX_AUX_DEF, `NRD_IDX_RX_CONF3, `NRD_IDX_NRT_CTRL,
		`NRD_IDX_IRQ_STAT, `NRD_IDX_COLLISION, `NRD_IDX_BR_DISPLAY,
		`NRD_IDX_COMMAND:
			mapped = 1'b1;
		default:
			mapped = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;

	// read data caught in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (idx)
			`NRD_IDX_IO_CFG1:     prdata_q <= {24'h00_0000, io_cfg1_q};
			`NRD_IDX_IO_CFG2:     prdata_q <= {24'h00_0000, io_cfg2_q};
			`NRD_IDX_OP_CTRL:     prdata_q <= {24'h00_0000, op_ctrl_q};
			`NRD_IDX_MODE_DEF:    prdata_q <= {24'h00_0000, mode_q};
			`NRD_IDX_BITRATE_DEF: prdata_q <= {24'h00_0000, bitrate_q};
			`NRD_IDX_TYPE_A:      prdata_q <= {24'h00_0000, type_a_q};
			`NRD_IDX_AUX_DEF:     prdata_q <= {24'h00_0000, aux_q};
			`NRD_IDX_RX_CONF3:    prdata_q <= {24'h00_0000, rxc3_q};
			`NRD_IDX_NRT_CTRL:    prdata_q <= {24'h00_0000, nrt_ctrl_q};
			`NRD_IDX_IRQ_STAT:    prdata_q <= {24'h00_0000, 6'h00, irq_q};
			`NRD_IDX_COLLISION:   prdata_q <= {24'h00_0000, coll_q};
			`NRD_IDX_BR_DISPLAY:  prdata_q <= {24'h00_0000, br_detected};
			default:              prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// command acceptance; refused commands simply drop
	assign do_setdef    = cmd_wr && cmd == `NRD_CMD_SET_DEFAULT; // [RULE3]
	assign do_clear     = cmd_wr && cmd == `NRD_CMD_CLEAR
	                      && en && freq_ok; // [RULE9] [RULE24]
	assign do_tx        = cmd_wr && op_ctrl_q[`NRD_OP_TX_EN]
	                      && (cmd == `NRD_CMD_TX_CRC
	                      || cmd == `NRD_CMD_TX_NOCRC
	                      || cmd == `NRD_CMD_TX_REQA
	                      || cmd == `NRD_CMD_TX_WUPA); // [RULE11] [RULE24]
	assign do_fon_init  = cmd_wr && cmd == `NRD_CMD_INIT_FIELD
	                      && en && freq_ok && ampl_ok; // [RULE18]
	assign do_fon_resp  = cmd_wr && cmd == `NRD_CMD_RESP_FIELD
	                      && en && freq_ok && ampl_ok; // [RULE18]
	assign do_fon_resp0 = cmd_wr && cmd == `NRD_CMD_RESP_FIELD0
	                      && en && freq_ok && ampl_ok; // [RULE18]

	assign om = mode_q[`NRD_MODE_OM_HI:`NRD_MODE_OM_LO];
	assign do_go_normal = cmd_wr && cmd == `NRD_CMD_GO_NORMAL
	                      && mode_q[`NRD_MODE_TARGET]
	                      && om == `NRD_OM_BR_DETECT;
	assign do_preset    = cmd_wr && cmd == `NRD_CMD_ANALOG_PRE;

	assign active_comm = mode_q[`NRD_MODE_TARGET]
	                     ? (om == `NRD_OM_NFC_TARGET)
	                     : (om == `NRD_OM_NFC_INIT);
	assign tx_am = bitrate_q[7:4] != 4'h0;

	// peer field dropping restarts response avoidance on its own
	assign auto_start = mode_q[`NRD_MODE_AUTO_RESP] && en
	                    && field_prev_q && !field
	                    && ca_q == nrd_pkg::NRD_CA_IDLE;
	assign ca_start = do_fon_init || do_fon_resp || do_fon_resp0
	                  || auto_start;
	assign ca_abort = do_setdef
	                  || (do_clear && !mode_q[`NRD_MODE_AUTO_RESP]); // [RULE7]

	assign slot_max  = {aux_q[`NRD_AUX_SLOT_HI], aux_q[`NRD_AUX_SLOT_LO]};
	assign slot_rand = (lfsr_q[1:0] > slot_max) ? slot_max : lfsr_q[1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lfsr_q <= 8'h01;
		else
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]
			           ^ lfsr_q[4] ^ lfsr_q[3]};
	end

	// collision avoidance sequencer
	assign ca_tick0 = cnt_q == 20'h0_0000;
	assign ca_cac   = (ca_q == nrd_pkg::NRD_CA_DELAY
	                  || ca_q == nrd_pkg::NRD_CA_SLOTS) && field; // [RULE14]
	assign ca_tx_on = !field && ca_tick0
	                  && ((ca_q == nrd_pkg::NRD_CA_DELAY && slots_q == 2'h0)
	                  || (ca_q == nrd_pkg::NRD_CA_SLOTS
	                  && slots_q == 2'h1)); // [RULE13]
	assign ca_cat   = ca_q == nrd_pkg::NRD_CA_GUARD && ca_tick0; // [RULE13]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ca_q      <= nrd_pkg::NRD_CA_IDLE;
			cnt_q     <= 20'h0_0000;
			slots_q   <= 2'h0;
			ca_init_q <= 1'b0;
		end else if (ca_abort) begin
			ca_q <= nrd_pkg::NRD_CA_IDLE;
		end else if (ca_start) begin
			ca_q      <= nrd_pkg::NRD_CA_DELAY;
			ca_init_q <= do_fon_init;
			cnt_q     <= (do_fon_init ? P_IDT_CYC : P_ADT_CYC)
			             - 20'h0_0001; // [RULE15] [RULE17]
			slots_q   <= do_fon_resp0 ? 2'h0 : slot_rand; // [RULE16]
		end else begin
			unique case (ca_q)
			nrd_pkg::NRD_CA_IDLE: begin
				cnt_q <= 20'h0_0000;
			end
			nrd_pkg::NRD_CA_DELAY, nrd_pkg::NRD_CA_SLOTS: begin
				if (field) begin
					ca_q <= nrd_pkg::NRD_CA_IDLE; // [RULE14]
				end else if (!ca_tick0) begin
					cnt_q <= cnt_q - 20'h0_0001;
				end else if (ca_tx_on) begin
					ca_q  <= nrd_pkg::NRD_CA_GUARD;
					cnt_q <= (ca_init_q ? P_IRFG_CYC : P_ARFG_CYC)
					         - 20'h0_0001; // [RULE15] [RULE17]
				end else begin
					ca_q  <= nrd_pkg::NRD_CA_SLOTS;
					cnt_q <= RWF_CYC - 20'h0_0001;
					if (ca_q == nrd_pkg::NRD_CA_SLOTS)
						slots_q <= slots_q - 2'h1;
				end
			end
			nrd_pkg::NRD_CA_GUARD: begin
				if (ca_tick0)
					ca_q <= nrd_pkg::NRD_CA_IDLE;
				else
					cnt_q <= cnt_q - 20'h0_0001;
			end
			endcase
		end
	end

	// registers the power-up reset alone may touch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_cfg1_q <= `NRD_RST_REG8;
			io_cfg2_q <= `NRD_RST_REG8;
			op_ctrl_q <= `NRD_RST_REG8;
		end else begin
			if (wr_acc && idx == `NRD_IDX_IO_CFG1)
				io_cfg1_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_IO_CFG2)
				io_cfg2_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_OP_CTRL)
				op_ctrl_q <= pwdata[7:0];
			if (ca_tx_on)
				op_ctrl_q[`NRD_OP_TX_EN] <= 1'b1; // [RULE13]
			if (do_preset && active_comm) begin
				op_ctrl_q[`NRD_OP_SINGLE_RX] <= 1'b1; // [RULE21]
				op_ctrl_q[`NRD_OP_TX_EN]     <= 1'b0; // [RULE21]
			end else if (do_preset && (mode_q[`NRD_MODE_TARGET]
			             || om == `NRD_OM_NFC_INIT)) begin
				op_ctrl_q[`NRD_OP_TX_EN] <= 1'b0; // [RULE22]
			end
		end
	end

	// registers cleared by restore defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q     <= `NRD_RST_REG8;
			bitrate_q  <= `NRD_RST_REG8;
			type_a_q   <= `NRD_RST_REG8;
			aux_q      <= `NRD_RST_REG8;
			rxc3_q     <= `NRD_RST_REG8;
			nrt_ctrl_q <= `NRD_RST_REG8;
		end else if (do_setdef) begin
			mode_q     <= `NRD_RST_REG8; // [RULE1]
			bitrate_q  <= `NRD_RST_REG8; // [RULE1]
			type_a_q   <= `NRD_RST_REG8; // [RULE1]
			aux_q      <= `NRD_RST_REG8; // [RULE1]
			rxc3_q     <= `NRD_RST_REG8; // [RULE1]
			nrt_ctrl_q <= `NRD_RST_REG8; // [RULE1]
		end else begin
			if (wr_acc && idx == `NRD_IDX_MODE_DEF)
				mode_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_BITRATE_DEF)
				bitrate_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_TYPE_A)
				type_a_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_AUX_DEF)
				aux_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_RX_CONF3)
				rxc3_q <= pwdata[7:0];
			if (wr_acc && idx == `NRD_IDX_NRT_CTRL)
				nrt_ctrl_q <= pwdata[7:0];
			if (do_go_normal) begin
				mode_q[`NRD_MODE_OM_HI:`NRD_MODE_OM_LO] <=
				    `NRD_OM_NFC_TARGET; // [RULE19]
				bitrate_q <= br_detected; // [RULE19]
				aux_q[`NRD_AUX_TX_MOD_TYPE] <=
				    br_detected[7:4] != 4'h0; // [RULE19]
			end
			if (do_preset) begin
				// [RULE20]
				type_a_q[`NRD_TYPE_A_START_LEN] <= active_comm; // [RULE23]
				aux_q[`NRD_AUX_FIELD_DET]       <= active_comm;
				aux_q[`NRD_AUX_TX_MOD_TYPE]     <= tx_am;
				rxc3_q[`NRD_RXC3_LIMIT]         <= active_comm;
				rxc3_q[`NRD_RXC3_GAIN_RED]      <= active_comm;
			end
		end
	end

	// event flags: a set in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 2'h0;
		end else begin
			if (do_clear || do_setdef)
				irq_q <= 2'h0; // [RULE8] [RULE4]
			if (ca_cat)
				irq_q[`NRD_IRQ_CAT] <= 1'b1; // [RULE13]
			if (ca_cac)
				irq_q[`NRD_IRQ_CAC] <= 1'b1; // [RULE14]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coll_q <= `NRD_RST_REG8;
		end else begin
			if (do_clear || do_setdef)
				coll_q <= `NRD_RST_REG8; // [RULE8]
			if (coll_evt)
				coll_q <= coll_pos;
		end
	end

	// action pulses; none of them marks completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trx_abort_q     <= 1'b0;
			fifo_clear_q    <= 1'b0;
			timers_stop_q   <= 1'b0;
			nrt_stop_q      <= 1'b0;
			calib_discard_q <= 1'b0;
			tx_start_q      <= 1'b0;
			tx_kind_q       <= 2'h0;
		end else begin
			trx_abort_q     <= do_clear || do_setdef; // [RULE5]
			fifo_clear_q    <= do_clear || (do_setdef && en); // [RULE3] [RULE5]
			timers_stop_q   <= do_clear || do_setdef; // [RULE5]
			nrt_stop_q      <= do_setdef || (do_clear
			                   && !nrt_ctrl_q[`NRD_NRT_KEEP]); // [RULE6]
			calib_discard_q <= do_setdef; // [RULE2]
			tx_start_q      <= do_tx;
			if (do_tx)
				tx_kind_q <= cmd[1:0] ^ 2'h0;
		end
	end

	assign op_ctrl       = op_ctrl_q;
	assign mode_def      = mode_q;
	assign bitrate_def   = bitrate_q;
	assign type_a_cfg    = type_a_q;
	assign aux_def       = aux_q;
	assign rx_conf3      = rxc3_q;
	assign trx_abort     = trx_abort_q;
	assign fifo_clear    = fifo_clear_q;
	assign timers_stop   = timers_stop_q;
	assign nrt_stop      = nrt_stop_q;
	assign calib_discard = calib_discard_q;
	assign tx_start      = tx_start_q;
	assign tx_kind       = tx_kind_q;
	assign irq_flags     = irq_q;
endmodule

// File: dv/nrd_cmd_exec_monitor.sv
`timescale 1ns/1ps
module nrd_cmd_exec_monitor (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// watched outputs
	input wire logic [7:0] op_ctrl,
	input wire logic [7:0] mode_def,
	input wire logic [7:0] aux_def,
	input wire logic       trx_abort,
	input wire logic       fifo_clear,
	input wire logic       timers_stop,
	input wire logic       calib_discard,
	input wire logic       tx_start,
	input wire logic [1:0] irq_flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_clr_en;
		$rose(fifo_clear) |-> $past(op_ctrl[7]);
	endproperty
	a_clr_en: assert property (p_clr_en)
		else $error("fifo cleared with master enable low");
	property p_clr_set;
		trx_abort && !calib_discard |-> fifo_clear && timers_stop;
	endproperty
	a_clr_set: assert property (p_clr_set)
		else $error("abort without fifo clear and timer stop");
	property p_clr_irq;
		trx_abort && !calib_discard |-> irq_flags == 2'b00;
	endproperty
	a_clr_irq: assert property (p_clr_irq)
		else $error("flags survive clear");
	property p_tx_en;
		tx_start |-> $past(op_ctrl[3]);
	endproperty
	a_tx_en: assert property (p_tx_en)
		else $error("transmit started with transmitter off");
	property p_done_tx;
		$rose(irq_flags[1]) |-> op_ctrl[3];
	endproperty
	a_done_tx: assert property (p_done_tx)
		else $error("avoidance done without field on");
	property p_coll_off;
		$rose(irq_flags[0]) |-> $stable(op_ctrl[3]);
	endproperty
	a_coll_off: assert property (p_coll_off)
		else $error("field switched on collision");
	property p_dflt;
		calib_discard |-> op_ctrl == $past(op_ctrl) && mode_def == 8'h00
			&& aux_def == 8'h00;
	endproperty
	a_dflt: assert property (p_dflt)
		else $error("restore defaults left wrong state");
	property p_dflt_irq;
		calib_discard |-> irq_flags == 2'b00 ##1 irq_flags == 2'b00;
	endproperty
	a_dflt_irq: assert property (p_dflt_irq)
		else $error("restore defaults raised a flag");
endmodule

bind nrd_cmd_exec nrd_cmd_exec_monitor u_nrd_cmd_exec_monitor (
	.pclk(pclk), .presetn(presetn), .op_ctrl(op_ctrl),
	.mode_def(mode_def), .aux_def(aux_def), .trx_abort(trx_abort),
	.fifo_clear(fifo_clear), .timers_stop(timers_stop),
	.calib_discard(calib_discard), .tx_start(tx_start),
	.irq_flags(irq_flags));

// File: dv/nrd_host_model.sv
`timescale 1ns/1ps
`include "nrd_cfg.svh"
module nrd_host_model (
	// clock
	input wire logic        pclk,
	// apb master
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic     [7:0]  paddr,
	output logic     [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	task automatic xfer(input logic w, input logic [5:0] i,
		input logic [7:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not look like a held request
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask

	// restore defaults is always sent alone, never chained
	task automatic cmd(input logic [7:0] c);
		logic [31:0] r;
		logic        e;
		// data transmit is prepared by a clear first
		if (c == `NRD_CMD_TX_CRC || c == `NRD_CMD_TX_NOCRC)
			xfer(1'b1, `NRD_IDX_COMMAND, `NRD_CMD_CLEAR, r, e);
		// last-byte bit count stays zero, kept outside this block
		xfer(1'b1, `NRD_IDX_COMMAND, c, r, e);
	endtask
endmodule

// File: dv/nrd_cmd_exec_test.sv
`timescale 1ns/1ps
`include "nrd_cfg.svh"
module nrd_cmd_exec_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, coll_pos, br_detected, v;
	logic [31:0] pwdata, prdata, r;
	logic        osc_freq_ok, osc_ampl_ok, ext_field, coll_evt, e;
	logic [7:0]  op_ctrl, mode_def, bitrate_def, type_a_cfg, aux_def;
	logic [7:0]  rx_conf3;
	logic        trx_abort, fifo_clear, timers_stop, nrt_stop;
	logic        calib_discard, tx_start;
	logic [1:0]  tx_kind, irq_flags;
	logic [5:0]  pul;
	int          miscompares, n_tests, seed, a, b, mdl[64];
	logic [5:0]  idx[9] = '{2, 3, 4, 5, 9, 12, 16, 26, 27};
	logic [7:0]  bad[5] = '{8'hC2, 8'hC4, 8'hC8, 8'hC9, 8'hCA};

	always #5 pclk = ~pclk;

	nrd_cmd_exec #(.P_IDT_CYC(20'd20), .P_ADT_CYC(20'd12),
		.P_ARFG_CYC(20'd16), .P_IRFG_CYC(20'd30)) u_nrd_cmd_exec (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_freq_ok(osc_freq_ok),
		.osc_ampl_ok(osc_ampl_ok), .ext_field(ext_field),
		.coll_evt(coll_evt), .coll_pos(coll_pos),
		.br_detected(br_detected), .op_ctrl(op_ctrl),
		.mode_def(mode_def), .bitrate_def(bitrate_def),
		.type_a_cfg(type_a_cfg), .aux_def(aux_def), .rx_conf3(rx_conf3),
		.trx_abort(trx_abort), .fifo_clear(fifo_clear),
		.timers_stop(timers_stop), .nrt_stop(nrt_stop),
		.calib_discard(calib_discard), .tx_start(tx_start),
		.tx_kind(tx_kind), .irq_flags(irq_flags));

	nrd_host_model u_nrd_host_model (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task wr(input logic [5:0] i, input logic [7:0] d);
		u_nrd_host_model.xfer(1'b1, i, d, r, e);
		mdl[i] = d;
	endtask

	task rd(input logic [5:0] i);
		u_nrd_host_model.xfer(1'b0, i, 8'h00, r, e);
		chk(r, mdl[i]);
	endtask

	task cmd(input logic [7:0] c);
		u_nrd_host_model.cmd(c);
		#1;
		pul = {calib_discard, tx_start, nrt_stop, timers_stop, fifo_clear,
			trx_abort};
	endtask

	// bounded wait for the avoidance sequence, times from command accept
	task wait_seq(input int f);
		a = -1;
		b = -1;
		for (int i = 0; i < 300 && b < 0; i++) begin
			@(posedge pclk);
			#1;
			if (op_ctrl[3] === 1'b1 && a < 0)
				a = i;
			if (irq_flags[f] === 1'b1)
				b = i;
		end
	endtask

	initial begin
		#100000;
		miscompares++;
		end_sim;
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{osc_freq_ok, osc_ampl_ok, ext_field, coll_evt} = 4'h0;
		coll_pos = 8'h00;
		br_detected = 8'h00;
		seed = 71743;
		foreach (mdl[i])
			mdl[i] = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (idx[i])
			rd(idx[i]);
		u_nrd_host_model.xfer(1'b0, 6'h3E, 8'h00, r, e);
		chk(e, 1);
		osc_freq_ok <= 1'b1;
		foreach (bad[i]) begin
			cmd(bad[i]);
			chk(pul, 0);
		end
		repeat (30) @(posedge pclk);
		chk(irq_flags, 0);
		wr(`NRD_IDX_OP_CTRL, 8'h80);
		wr(`NRD_IDX_NRT_CTRL, 8'h01);
		// amplitude still unstable, so field-on must be dropped
		cmd(`NRD_CMD_INIT_FIELD);
		wait_seq(1);
		chk(a, -1);
		chk(b, -1);
		@(posedge pclk);
		osc_ampl_ok <= 1'b1;
		v = 8'($random(seed));
		coll_pos <= v;
		coll_evt <= 1'b1;
		@(posedge pclk);
		coll_evt <= 1'b0;
		mdl[27] = v;
		rd(`NRD_IDX_COLLISION);
		cmd(`NRD_CMD_CLEAR);
		chk(pul, 6'b000111);
		mdl[27] = 0;
		rd(`NRD_IDX_COLLISION);
		wr(`NRD_IDX_NRT_CTRL, 8'h00);
		cmd(`NRD_CMD_CLEAR);
		chk(pul, 6'b001111);
		cmd(`NRD_CMD_RESP_FIELD0);
		wait_seq(1);
		chk(a >= 11 && a <= 14, 1);
		chk(b - a >= 15 && b - a <= 18, 1);
		mdl[2] = 8'h88;
		mdl[26] = 2;
		rd(`NRD_IDX_OP_CTRL);
		rd(`NRD_IDX_IRQ_STAT);
		for (int k = 0; k < 4; k++) begin
			cmd(`NRD_CMD_TX_CRC + 8'(k));
			chk(pul[4], 1);
			chk(tx_kind, k);
		end
		mdl[26] = 0;
		rd(`NRD_IDX_IRQ_STAT);
		wr(`NRD_IDX_OP_CTRL, 8'h80);
		cmd(`NRD_CMD_TX_REQA);
		chk(pul[4], 0);
		@(posedge pclk);
		ext_field <= 1'b1;
		repeat (3) @(posedge pclk);
		cmd(`NRD_CMD_INIT_FIELD);
		wait_seq(0);
		chk(irq_flags, 2'b01);
		chk(op_ctrl, 8'h80);
		@(posedge pclk);
		ext_field <= 1'b0;
		repeat (3) @(posedge pclk);
		// repeated once no foreign carrier is seen
		cmd(`NRD_CMD_INIT_FIELD);
		wait_seq(1);
		chk(a >= 19 && a <= 23, 1);
		chk(b - a >= 30 && b - a <= 33, 1);
		// under auto response a clear must not stop the sequence
		wr(`NRD_IDX_OP_CTRL, 8'h80);
		wr(`NRD_IDX_MODE_DEF, 8'h01);
		cmd(`NRD_CMD_RESP_FIELD0);
		cmd(`NRD_CMD_CLEAR);
		wait_seq(1);
		chk(a >= 0 && b - a >= 15 && b - a <= 18, 1);
		wr(`NRD_IDX_OP_CTRL, 8'h08);
		wr(`NRD_IDX_MODE_DEF, 8'h07);
		wr(`NRD_IDX_AUX_DEF, 8'h03);
		cmd(`NRD_CMD_SET_DEFAULT);
		chk({pul[5], pul[1]}, 2'b10);
		foreach (mdl[i])
			if (i > 2)
				mdl[i] = 0;
		foreach (idx[i])
			rd(idx[i]);
		wr(`NRD_IDX_OP_CTRL, 8'h80);
		cmd(`NRD_CMD_SET_DEFAULT);
		chk(pul[1], 1);
		@(posedge pclk);
		v = 8'($random(seed));
		br_detected <= v;
		cmd(`NRD_CMD_GO_NORMAL);
		chk(pul, 0);
		wr(`NRD_IDX_MODE_DEF, 8'h90);
		cmd(`NRD_CMD_GO_NORMAL);
		mdl[3] = 8'h88;
		mdl[4] = v;
		mdl[9] = (v[7:4] != 0) ? 8'h20 : 8'h00;
		mdl[28] = v;
		foreach (mdl[i])
			if (i == 3 || i == 4 || i == 9 || i == 28)
				rd(6'(i));
		wr(`NRD_IDX_OP_CTRL, 8'h88);
		wr(`NRD_IDX_MODE_DEF, 8'h08);
		cmd(`NRD_CMD_ANALOG_PRE);
		mdl[2] = 8'hA0;
		mdl[5] = 8'h20;
		mdl[9] = mdl[9] | 8'h10;
		mdl[12] = 8'h03;
		rd(`NRD_IDX_OP_CTRL);
		rd(`NRD_IDX_TYPE_A);
		rd(`NRD_IDX_AUX_DEF);
		rd(`NRD_IDX_RX_CONF3);
		chk(type_a_cfg, mdl[5]);
		chk(rx_conf3, mdl[12]);
		chk(aux_def, mdl[9]);
		chk(bitrate_def, mdl[4]);
		chk(mode_def, mdl[3]);
		wr(`NRD_IDX_OP_CTRL, 8'h88);
		wr(`NRD_IDX_MODE_DEF, 8'hA0);
		cmd(`NRD_CMD_ANALOG_PRE);
		mdl[2] = 8'h80;
		rd(`NRD_IDX_OP_CTRL);
		end_sim;
	end
endmodule
